//--- design/uhpm_pkg.sv
// Operation
// - Device suspends 3ms after frames stop
// - Downstream resume within 1ms, held 20ms
// - Set frame generation first, then send resume
// - Descriptor base written; device fetches descriptors there
// - Initialise every bank's descriptor words before use
// - Pipe word: faults, limit, endpoint, address
// - Halt, wait halted, clear faults, release
// - Control stages; Data0 for SETUP, else Data1
// - Received-flag clear leaves bank state alone
// - Clear flag, read count and data, free bank
// - Read current bank index to find bank
package uhpm_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned SUSPEND_SETTLE_US = 3000;
  localparam int unsigned RESUME_START_MAX_US = 1000;
  localparam int unsigned RESUME_HOLD_US = 20000;
  localparam int unsigned SUSPEND_SETTLE_CYC = SUSPEND_SETTLE_US * CLK_MHZ;
  localparam int unsigned RESUME_START_MAX_CYC = RESUME_START_MAX_US * CLK_MHZ;
  localparam int unsigned RESUME_HOLD_CYC = RESUME_HOLD_US * CLK_MHZ;
  localparam int unsigned TMR_W = 21;
  localparam logic [20:0] SETTLE_CYC = 21'h000004;
  // ****************************************************************
  // Own registers
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_BASE = 12'h004;
  localparam logic [11:0] OFS_CFG = 12'h008;
  localparam logic [11:0] OFS_BADDR0 = 12'h00C;
  localparam logic [11:0] OFS_BADDR1 = 12'h010;
  localparam logic [11:0] OFS_MPS = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_RXCNT = 12'h01C;
  localparam logic [11:0] OFS_RXSUM = 12'h020;
  localparam int unsigned CMD_INIT = 0;
  localparam int unsigned CMD_START = 1;
  localparam int unsigned CMD_HALT = 2;
  localparam int unsigned CMD_SUSPEND = 3;
  localparam int unsigned CMD_CLRFLT = 4;
  localparam int unsigned CMD_WAKE = 5;
  localparam int unsigned CFG_CONT = 8;
  localparam int unsigned CFG_TOK_LO = 9;
  localparam int unsigned CFG_ZLP = 11;
  localparam int unsigned CFG_LIM_LO = 12;
  localparam int unsigned CFG_EP_LO = 16;
  localparam int unsigned CFG_DEV_LO = 20;
  localparam int unsigned CFG_IRQEN = 27;
  localparam int unsigned ST_WAKE = 4;
  localparam int unsigned ST_RSM = 5;
  // ****************************************************************
  // Descriptor layout
  // ****************************************************************
  localparam logic [1:0] DW_ADDR = 2'h0;
  localparam logic [1:0] DW_PCK = 2'h1;
  localparam logic [1:0] DW_BSTA = 2'h2;
  localparam logic [1:0] DW_PSTA = 2'h3;
  localparam int unsigned PCK_ZLP = 31;
  localparam int unsigned PCK_MPS_LO = 16;
  localparam int unsigned PCK_CNT_HI = 14;
  localparam int unsigned BSTA_LO = 16;
  localparam int unsigned PSTA_FLT_LO = 16;
  localparam int unsigned PSTA_LIM_LO = 12;
  localparam int unsigned PSTA_EP_LO = 8;
  localparam logic [7:0] FLT_CLEAR = 8'h00;
  // Sync vector bit positions
  localparam int unsigned SY_WAKE = 0;
  localparam int unsigned SY_RSM = 1;
  localparam int unsigned SY_RX = 2;
  localparam int unsigned SY_HO = 3;
  localparam int unsigned SY_BANK = 4;
  localparam int unsigned SY_HALTED = 5;
  localparam int unsigned SY_FAULT = 6;
  localparam int unsigned SY_IRQ = 7;

  typedef enum logic [1:0] {
    UHPM_TOK_SETUP = 2'h0,
    UHPM_TOK_IN = 2'h1,
    UHPM_TOK_OUT = 2'h2
  } uhpm_tok_e;

  typedef enum logic [15:0] {
    S_IDLE = 16'h0001,
    S_INIT = 16'h0002,
    S_RX_ACK = 16'h0004,
    S_RX_PCK = 16'h0008,
    S_RX_STA = 16'h0010,
    S_RX_PSTA = 16'h0020,
    S_RX_DATA = 16'h0040,
    S_RX_ZERO = 16'h0080,
    S_RX_FREE = 16'h0100,
    S_RX_SETTLE = 16'h0200,
    S_CLR_HALT = 16'h0400,
    S_CLR_RD = 16'h0800,
    S_CLR_WR = 16'h1000,
    S_RES_READY = 16'h2000,
    S_RES_SEND = 16'h4000,
    S_RES_HOLD = 16'h8000
  } uhpm_state_e;

  function automatic logic [31:0] uhpm_desc_addr(input logic [31:0] base, input logic bank,
                                                 input logic [1:0] word);
    uhpm_desc_addr = base + {27'h0, bank, word, 2'h0};
  endfunction

  function automatic logic uhpm_init_toggle(input logic [1:0] tok);
    uhpm_init_toggle = (tok != UHPM_TOK_SETUP);
  endfunction
endpackage

//--- design/uhpm_timer.sv
module uhpm_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic load,
  input wire logic [uhpm_pkg::TMR_W-1:0] load_val,
  output logic expired
);
  import uhpm_pkg::*;
  logic [TMR_W-1:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0);
endmodule // uhpm_timer

//--- design/uhpm_host.sv
module uhpm_host #(
  parameter int unsigned SUSPEND_CYC = uhpm_pkg::SUSPEND_SETTLE_CYC,
  parameter int unsigned RESUME_CYC = uhpm_pkg::RESUME_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic frame_generation_enable,
  output logic send_resume,
  output logic host_wakeup_clear,
  output logic [31:0] descriptor_table_base,
  output logic pipe_halt,
  output logic continuous_request_mode,
  output logic [7:0] in_request_quota,
  output logic [1:0] token_kind,
  output logic init_toggle,
  output logic in_data_irq_enable,
  output logic in_data_flag_clear,
  output logic bank_handoff_clear,
  input wire logic host_wakeup_flag,
  input wire logic upstream_resume_received_flag,
  input wire logic in_data_received_flag,
  input wire logic bank_handoff_control,
  input wire logic current_bank_index,
  input wire logic pipe_halted,
  input wire logic pipe_fault_flag,
  input wire logic pipe_irq,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  import uhpm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  uhpm_state_e state_q, state_d;
  logic [7:0] sy1_q, sy2_q;
  logic fge_q, fge_d, res_q, res_d, wclr_q, wclr_d, fclr_q, fclr_d, hclr_q, hclr_d;
  logic halt_q, halt_d, armed_q, armed_d, settled_q, settled_d;
  logic [31:0] base_q, base_d, cfg_q, cfg_d, ba0_q, ba0_d, ba1_q, ba1_d;
  logic [14:0] mps_q, mps_d, bytes_q, bytes_d;
  logic [12:0] words_q, words_d, idx_q, idx_d;
  logic [16:0] pckhi_q, pckhi_d;
  logic [31:0] psta_q, psta_d, total_q, total_d, sum_q, sum_d;
  logic [2:0] bsta_q, bsta_d;
  logic [7:0] flt_q, flt_d;
  logic bank_q, bank_d, wseen_q, wseen_d, rseen_q, rseen_d;
  logic mreq_q, mreq_d, mwe_q, mwe_d;
  logic [31:0] maddr_q, maddr_d, mwd_q, mwd_d, prd_q, prd_d;
  logic prdy_q, prdy_d, perr_q, perr_d;
  logic ta_load, tb_load, ta_exp, tb_exp;
  logic [TMR_W-1:0] tb_val;
  logic wr_en, idle, s_wake, s_rsm, s_rx, s_ho, s_bank, s_halted, s_fault, s_irq;
  logic [31:0] status;

  assign s_wake = sy2_q[SY_WAKE];
  assign s_rsm = sy2_q[SY_RSM];
  assign s_rx = sy2_q[SY_RX];
  assign s_ho = sy2_q[SY_HO];
  assign s_bank = sy2_q[SY_BANK];
  assign s_halted = sy2_q[SY_HALTED];
  assign s_fault = sy2_q[SY_FAULT];
  assign s_irq = sy2_q[SY_IRQ];
  assign idle = (state_q == S_IDLE);
  assign wr_en = psel & penable & prdy_q & pwrite;
  assign status = {flt_q, 11'h0, bsta_q, s_irq, s_halted, bank_q, s_fault, rseen_q,
                   wseen_q, 1'b0, settled_q, ~fge_q, ~idle};

  uhpm_timer u_susp_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(ta_load),
    .load_val(TMR_W'(SUSPEND_CYC)),
    .expired(ta_exp)
  );

  uhpm_timer u_wait_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(tb_load),
    .load_val(tb_val),
    .expired(tb_exp)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    fge_d = fge_q;
    res_d = 1'b0;
    wclr_d = 1'b0;
    fclr_d = 1'b0;
    hclr_d = 1'b0;
    halt_d = halt_q;
    armed_d = armed_q;
    settled_d = armed_q & ~fge_q & ta_exp & ~ta_load;
    base_d = base_q;
    cfg_d = cfg_q;
    ba0_d = ba0_q;
    ba1_d = ba1_q;
    mps_d = mps_q;
    bytes_d = bytes_q;
    words_d = words_q;
    idx_d = idx_q;
    pckhi_d = pckhi_q;
    psta_d = psta_q;
    total_d = total_q;
    sum_d = sum_q;
    bsta_d = bsta_q;
    flt_d = flt_q;
    bank_d = bank_q;
    wseen_d = wseen_q;
    rseen_d = rseen_q;
    mreq_d = mreq_q;
    mwe_d = mwe_q;
    maddr_d = maddr_q;
    mwd_d = mwd_q;
    ta_load = 1'b0;
    tb_load = 1'b0;
    tb_val = SETTLE_CYC;
    prdy_d = psel & ~penable & ~prdy_q;
    perr_d = 1'b0;
    prd_d = prd_q;
    // Register reads prepared in the setup cycle, answered one edge later
    if (psel & ~penable) begin
      case (paddr)
        OFS_CTRL: prd_d = 32'h0;
        OFS_BASE: prd_d = base_q;
        OFS_CFG: prd_d = cfg_q;
        OFS_BADDR0: prd_d = ba0_q;
        OFS_BADDR1: prd_d = ba1_q;
        OFS_MPS: prd_d = {17'h0, mps_q};
        OFS_STATUS: prd_d = status;
        OFS_RXCNT: prd_d = total_q;
        OFS_RXSUM: prd_d = sum_q;
        default: begin
          prd_d = 32'h0;
          perr_d = 1'b1;
        end
      endcase
    end
    if (wr_en) begin
      case (paddr)
        OFS_BASE: base_d = pwdata;
        OFS_CFG: cfg_d = pwdata;
        OFS_BADDR0: ba0_d = pwdata;
        OFS_BADDR1: ba1_d = pwdata;
        OFS_MPS: mps_d = pwdata[14:0];
        default: ;
      endcase
      if (paddr == OFS_CTRL && pwdata[CMD_START]) begin
        halt_d = 1'b0;
      end
      if (paddr == OFS_CTRL && pwdata[CMD_HALT]) begin
        halt_d = 1'b1;
      end
    end
    // Write-one clears of sticky events; a new event below wins
    if (wr_en && paddr == OFS_STATUS) begin
      wseen_d = wseen_q & ~pwdata[ST_WAKE];
      rseen_d = rseen_q & ~pwdata[ST_RSM];
    end
    case (state_q)
      S_IDLE: begin
        if (~fge_q & s_wake) begin
          wseen_d = 1'b1;
          wclr_d = 1'b1;
          if (s_rsm) begin
            rseen_d = 1'b1;
            state_d = S_RES_READY;
          end
        end else if (wr_en && paddr == OFS_CTRL) begin
          if (pwdata[CMD_WAKE] & ~fge_q) begin
            state_d = S_RES_READY;
          end else if (pwdata[CMD_SUSPEND]) begin
            fge_d = 1'b0;
            armed_d = 1'b1;
            ta_load = 1'b1;
          end else if (pwdata[CMD_CLRFLT]) begin
            state_d = S_CLR_HALT;
          end else if (pwdata[CMD_INIT]) begin
            idx_d = 13'h0;
            state_d = S_INIT;
          end
        end else if (fge_q & s_rx & s_ho & s_irq) begin
          state_d = S_RX_ACK;
        end
      end
      S_INIT: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwe_d = 1'b1;
          maddr_d = uhpm_desc_addr(base_q, idx_q[2], idx_q[1:0]);
          case (idx_q[1:0])
            DW_ADDR: mwd_d = idx_q[2] ? ba1_q : ba0_q;
            DW_PCK: mwd_d = {cfg_q[CFG_ZLP], mps_q, 16'h0};
            DW_BSTA: mwd_d = 32'h0;
            default: mwd_d = {8'h0, FLT_CLEAR, cfg_q[CFG_LIM_LO +: 4], cfg_q[CFG_EP_LO +: 4],
                              1'b0, cfg_q[CFG_DEV_LO +: 7]};
          endcase
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          idx_d = idx_q + 13'h1;
          if (idx_q == 13'h7) begin
            state_d = S_IDLE;
          end
        end
      end
      S_RX_ACK: begin
        fclr_d = 1'b1;
        bank_d = s_bank;
        state_d = S_RX_PCK;
      end
      S_RX_PCK, S_RX_STA, S_RX_PSTA: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwe_d = 1'b0;
          maddr_d = uhpm_desc_addr(base_q, bank_q, (state_q == S_RX_PCK) ? DW_PCK :
                                   (state_q == S_RX_STA) ? DW_BSTA : DW_PSTA);
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          if (state_q == S_RX_PCK) begin
            bytes_d = mem_rdata[PCK_CNT_HI:0];
            words_d = 13'((16'(mem_rdata[PCK_CNT_HI:0]) + 16'h3) >> 2);
            pckhi_d = mem_rdata[31:15];
            state_d = S_RX_STA;
          end else if (state_q == S_RX_STA) begin
            bsta_d = mem_rdata[BSTA_LO +: 3];
            state_d = S_RX_PSTA;
          end else begin
            flt_d = mem_rdata[PSTA_FLT_LO +: 8];
            idx_d = 13'h0;
            state_d = S_RX_DATA;
          end
        end
      end
      S_RX_DATA: begin
        if (idx_q == words_q) begin
          total_d = total_q + {17'h0, bytes_q};
          state_d = S_RX_ZERO;
        end else if (!mreq_q) begin
          mreq_d = 1'b1;
          mwe_d = 1'b0;
          maddr_d = (bank_q ? ba1_q : ba0_q) + {17'h0, idx_q, 2'h0};
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          sum_d = sum_q + mem_rdata;
          idx_d = idx_q + 13'h1;
        end
      end
      S_RX_ZERO: begin
        // Byte count accumulates per packet, so it is rearmed at zero
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwe_d = 1'b1;
          maddr_d = uhpm_desc_addr(base_q, bank_q, DW_PCK);
          mwd_d = {pckhi_q, 15'h0};
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          state_d = S_RX_FREE;
        end
      end
      S_RX_FREE: begin
        hclr_d = 1'b1;
        tb_load = 1'b1;
        state_d = S_RX_SETTLE;
      end
      S_RX_SETTLE: begin
        // Synchronised flags lag the clears; avoid a false second pass
        if (tb_exp) begin
          state_d = S_IDLE;
        end
      end
      S_CLR_HALT: begin
        halt_d = 1'b1;
        if (s_halted & halt_q) begin
          state_d = S_CLR_RD;
        end
      end
      S_CLR_RD: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwe_d = 1'b0;
          maddr_d = uhpm_desc_addr(base_q, 1'b0, DW_PSTA);
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          psta_d = mem_rdata;
          idx_d = 13'h0;
          state_d = S_CLR_WR;
        end
      end
      S_CLR_WR: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwe_d = 1'b1;
          maddr_d = uhpm_desc_addr(base_q, idx_q[0], DW_PSTA);
          mwd_d = {psta_q[31:24], FLT_CLEAR, psta_q[15:0]};
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          idx_d = idx_q + 13'h1;
          if (idx_q[0]) begin
            flt_d = FLT_CLEAR;
            halt_d = 1'b0;
            state_d = S_IDLE;
          end
        end
      end
      S_RES_READY: begin
        fge_d = 1'b1;
        armed_d = 1'b0;
        state_d = S_RES_SEND;
      end
      S_RES_SEND: begin
        res_d = 1'b1;
        tb_load = 1'b1;
        tb_val = TMR_W'(RESUME_CYC);
        state_d = S_RES_HOLD;
      end
      S_RES_HOLD: begin
        if (tb_exp) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      sy1_q <= 8'h00;
      sy2_q <= 8'h00;
      fge_q <= 1'b1;
      res_q <= 1'b0;
      wclr_q <= 1'b0;
      fclr_q <= 1'b0;
      hclr_q <= 1'b0;
      halt_q <= 1'b1;
      armed_q <= 1'b0;
      settled_q <= 1'b0;
      base_q <= 32'h0;
      cfg_q <= 32'h0;
      ba0_q <= 32'h0;
      ba1_q <= 32'h0;
      mps_q <= 15'h0;
      bytes_q <= 15'h0;
      words_q <= 13'h0;
      idx_q <= 13'h0;
      pckhi_q <= 17'h0;
      psta_q <= 32'h0;
      total_q <= 32'h0;
      sum_q <= 32'h0;
      bsta_q <= 3'h0;
      flt_q <= 8'h00;
      bank_q <= 1'b0;
      wseen_q <= 1'b0;
      rseen_q <= 1'b0;
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      maddr_q <= 32'h0;
      mwd_q <= 32'h0;
      prd_q <= 32'h0;
      prdy_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      sy1_q <= {pipe_irq, pipe_fault_flag, pipe_halted, current_bank_index,
                bank_handoff_control, in_data_received_flag, upstream_resume_received_flag,
                host_wakeup_flag};
      sy2_q <= sy1_q;
      fge_q <= fge_d;
      res_q <= res_d;
      wclr_q <= wclr_d;
      fclr_q <= fclr_d;
      hclr_q <= hclr_d;
      halt_q <= halt_d;
      armed_q <= armed_d;
      settled_q <= settled_d;
      base_q <= base_d;
      cfg_q <= cfg_d;
      ba0_q <= ba0_d;
      ba1_q <= ba1_d;
      mps_q <= mps_d;
      bytes_q <= bytes_d;
      words_q <= words_d;
      idx_q <= idx_d;
      pckhi_q <= pckhi_d;
      psta_q <= psta_d;
      total_q <= total_d;
      sum_q <= sum_d;
      bsta_q <= bsta_d;
      flt_q <= flt_d;
      bank_q <= bank_d;
      wseen_q <= wseen_d;
      rseen_q <= rseen_d;
      mreq_q <= mreq_d;
      mwe_q <= mwe_d;
      maddr_q <= maddr_d;
      mwd_q <= mwd_d;
      prd_q <= prd_d;
      prdy_q <= prdy_d;
      perr_q <= perr_d;
    end
  end

  assign prdata = prd_q;
  assign pready = prdy_q;
  assign pslverr = perr_q;
  assign frame_generation_enable = fge_q;
  assign send_resume = res_q;
  assign host_wakeup_clear = wclr_q;
  assign descriptor_table_base = base_q;
  assign pipe_halt = halt_q;
  assign continuous_request_mode = cfg_q[CFG_CONT];
  assign in_request_quota = cfg_q[7:0];
  assign token_kind = cfg_q[CFG_TOK_LO +: 2];
  assign init_toggle = uhpm_init_toggle(cfg_q[CFG_TOK_LO +: 2]);
  assign in_data_irq_enable = cfg_q[CFG_IRQEN];
  assign in_data_flag_clear = fclr_q;
  assign bank_handoff_clear = hclr_q;
  assign mem_req = mreq_q;
  assign mem_we = mwe_q;
  assign mem_addr = maddr_q;
  assign mem_wdata = mwd_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence wake_k_s;
    ce && idle && !fge_q && s_wake && s_rsm;
  endsequence
  sequence resume_seq_s;
    ce && state_q == S_RES_READY ##1 ce && state_q == S_RES_SEND;
  endsequence

  suspend_stop_a: assert property (ce && idle && !s_wake && wr_en &&
    paddr == OFS_CTRL && pwdata[CMD_SUSPEND] && !pwdata[CMD_WAKE] |=> !frame_generation_enable)
    else $error("frame generation not stopped on suspend");
  wake_flag_a: assert property (wake_k_s |=> wseen_q && rseen_q)
    else $error("wakeup event not recorded");
  resume_start_a: assert property (wake_k_s |-> ##[2:4] send_resume)
    else $error("downstream resume not started promptly");
  resume_order_a: assert property (resume_seq_s |=>
    send_resume && frame_generation_enable)
    else $error("resume sent before frame generation restored");
  resume_hold_a: assert property (send_resume |-> !idle [*8])
    else $error("resume hold ended too early");
  desc_fetch_a: assert property (mem_req && state_q == S_RX_PCK |->
    mem_addr == uhpm_desc_addr(descriptor_table_base, bank_q, DW_PCK))
    else $error("count fetched from wrong descriptor word");
  init_zero_a: assert property (mem_req && state_q == S_INIT &&
    idx_q[1:0] == DW_PCK |-> mem_we && mem_wdata[PCK_CNT_HI:0] == 15'h0)
    else $error("byte count not zeroed at init");
  ack_first_a: assert property (in_data_flag_clear |-> ##[3:1000] bank_handoff_clear)
    else $error("bank not freed after flag clear");
  halt_clear_a: assert property (mem_req && mem_we && state_q == S_CLR_WR |->
    pipe_halt && mem_wdata[23:16] == FLT_CLEAR)
    else $error("fault field cleared while pipe running");
endmodule // uhpm_host

//--- tb/uhpm_dev_model.sv
module uhpm_dev_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wk,
  input wire logic rx_go,
  input wire logic frame_generation_enable,
  input wire logic send_resume,
  input wire logic host_wakeup_clear,
  input wire logic pipe_halt,
  input wire logic in_data_irq_enable,
  input wire logic in_data_flag_clear,
  input wire logic bank_handoff_clear,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic host_wakeup_flag,
  output logic upstream_resume_received_flag,
  output logic in_data_received_flag,
  output logic bank_handoff_control,
  output logic current_bank_index,
  output logic pipe_halted,
  output logic pipe_fault_flag,
  output logic pipe_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ram [64];
  assign pipe_fault_flag = 1'b0;
  assign pipe_irq = in_data_received_flag & in_data_irq_enable;
  // Plain always: the bench preloads this memory as well
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mem_ack, host_wakeup_flag, upstream_resume_received_flag} <= 3'h0;
      {in_data_received_flag, bank_handoff_control, current_bank_index} <= 3'h0;
      pipe_halted <= 1'b1;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= mem_req & ~mem_ack;
      // Stale read data inverts every cycle, so it looks valid only every second cycle
      mem_rdata <= ~mem_rdata;
      if (mem_req & ~mem_ack) begin
        mem_rdata <= ram[mem_addr[7:2]];
        if (mem_we) ram[mem_addr[7:2]] <= mem_wdata;
      end
      pipe_halted <= pipe_halt;
      if (wk & ~frame_generation_enable) begin
        host_wakeup_flag <= 1'b1;
        upstream_resume_received_flag <= 1'b1;
      end else if (host_wakeup_clear) host_wakeup_flag <= 1'b0;
      if (send_resume) upstream_resume_received_flag <= 1'b0;
      if (rx_go & ~pipe_halt) {in_data_received_flag, bank_handoff_control} <= 2'h3;
      if (in_data_flag_clear) in_data_received_flag <= 1'b0;
      if (bank_handoff_clear) begin
        bank_handoff_control <= 1'b0;
        current_bank_index <= ~current_bank_index;
      end
    end
  end
endmodule // uhpm_dev_model

//--- tb/usb_host_pipe_manager_test.sv
module usb_host_pipe_manager_test;
  timeunit 1ns;
  timeprecision 1ps;
  import uhpm_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, wk = 0, rx_go = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, mem_rdata, mem_wdata, mem_addr, descriptor_table_base, r;
  logic [7:0] in_request_quota;
  logic [1:0] token_kind;
  logic pready, pslverr, frame_generation_enable, send_resume, host_wakeup_clear, pipe_halt;
  logic continuous_request_mode, init_toggle, in_data_irq_enable, in_data_flag_clear;
  logic bank_handoff_clear, host_wakeup_flag, upstream_resume_received_flag, mem_ack;
  logic in_data_received_flag, bank_handoff_control, current_bank_index, pipe_halted;
  logic pipe_fault_flag, pipe_irq, mem_req, mem_we, e;
  int fail_count = 0, samples_checked = 0, i;
  uhpm_host #(.SUSPEND_CYC(20), .RESUME_CYC(40)) uhpm_host_inst (.*);
  uhpm_dev_model uhpm_dev_model_inst (.*);
  always #10 pclk = ~pclk;
  task chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task idle();
    repeat (4) @(posedge pclk);
    for (i = 0; i < 300; i++) begin
      apb(0, OFS_STATUS, 0);
      if (r[0] === 1'b0) break;
    end
    chk(r[0], 1'b0);
  endtask
  task t_reset();
    chk({frame_generation_enable, pipe_halt}, 2'h3);
    apb(0, 12'h0FC, 0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    $display("reset done");
  endtask
  task t_wake();
    apb(1, OFS_CTRL, 32'h8);
    chk(frame_generation_enable, 0);
    ce <= 0;
    repeat (30) @(posedge pclk);
    ce <= 1;
    apb(0, OFS_STATUS, 0);
    chk(r[2:0], 3'h2);
    repeat (30) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk(r[2:0], 3'h6);
    wk <= 1;
    @(posedge pclk) wk <= 0;
    for (i = 0; i < 50 && send_resume !== 1'b1; i++) @(posedge pclk);
    chk({send_resume, frame_generation_enable}, 2'h3);
    idle();
    chk(r[5:4], 2'h3);
    $display("wake done");
  endtask
  task t_rx();
    apb(1, OFS_BASE, 32'h40);
    apb(1, OFS_CFG, 32'h0);
    chk(init_toggle, 0);
    apb(1, OFS_CFG, 32'h08523201);
    chk({token_kind, init_toggle}, 3'h3);
    chk({in_data_irq_enable, continuous_request_mode, in_request_quota}, 10'h201);
    apb(1, OFS_BADDR0, 32'h80);
    apb(1, OFS_MPS, 32'h40);
    apb(1, OFS_CTRL, 32'h1);
    idle();
    chk(descriptor_table_base, 32'h40);
    chk(uhpm_dev_model_inst.ram[16], 32'h80);
    chk(uhpm_dev_model_inst.ram[17], 32'h00400000);
    chk(uhpm_dev_model_inst.ram[19], 32'h00003205);
    uhpm_dev_model_inst.ram[18] = 32'h00070000;
    uhpm_dev_model_inst.ram[19][23:16] = 8'hA5;
    uhpm_dev_model_inst.ram[17][14:0] = 15'h8;
    uhpm_dev_model_inst.ram[32] = 32'h11;
    uhpm_dev_model_inst.ram[33] = 32'h22;
    apb(1, OFS_CTRL, 32'h2);
    chk(pipe_halt, 0);
    rx_go <= 1;
    @(posedge pclk) rx_go <= 0;
    idle();
    chk({r[31:24], r[12:10]}, 11'h52F);
    apb(0, OFS_RXCNT, 0);
    chk(r, 32'h8);
    apb(0, OFS_RXSUM, 0);
    chk(r, 32'h33);
    chk(uhpm_dev_model_inst.ram[17][14:0], 15'h0);
    chk({current_bank_index, bank_handoff_control}, 2'h2);
    $display("rx done");
  endtask
  task t_clr();
    apb(1, OFS_CTRL, 32'h10);
    idle();
    chk(r[31:24], 8'h0);
    chk(uhpm_dev_model_inst.ram[19], 32'h00003205);
    chk(uhpm_dev_model_inst.ram[23], 32'h00003205);
    chk(pipe_halt, 0);
    $display("clear done");
  endtask
  task t_swake();
    apb(1, OFS_CTRL, 32'h8);
    apb(1, OFS_CTRL, 32'h20);
    for (i = 0; i < 50 && send_resume !== 1'b1; i++) @(posedge pclk);
    chk({send_resume, frame_generation_enable}, 2'h3);
    idle();
    $display("resume done");
  endtask
  task complete_run();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_wake();
    t_rx();
    t_clr();
    t_swake();
    complete_run();
  end
  initial begin
    #400us;
    fail_count++;
    complete_run();
  end
endmodule // usb_host_pipe_manager_test
